// *** hw/pms_pkg.sv ***
package pms_pkg;

  // Link command and data widths.
  localparam int unsigned PMS_CMD_W = 8;
  localparam int unsigned PMS_DATA_W = 16;

  // Command codes of the status bank, plus the alert mask command.
  localparam logic [7:0] PMS_CMD_SUMMARY = 8'h79;
  localparam logic [7:0] PMS_CMD_VOUT = 8'h7A;
  localparam logic [7:0] PMS_CMD_IOUT = 8'h7B;
  localparam logic [7:0] PMS_CMD_INPUT = 8'h7C;
  localparam logic [7:0] PMS_CMD_ALERT_MASK = 8'h1B;

  // Output voltage flag positions.
  localparam int unsigned PMS_VOUT_OV_FAULT = 7;
  localparam int unsigned PMS_VOUT_OV_WARN = 6;
  localparam int unsigned PMS_VOUT_UV_WARN = 5;
  localparam int unsigned PMS_VOUT_UV_FAULT = 4;
  localparam int unsigned PMS_VOUT_MAX_WARN = 3;
  localparam int unsigned PMS_VOUT_TON_TIMEOUT = 2;

  // Output current and input flag positions.
  localparam int unsigned PMS_IOUT_OC_FAULT = 7;
  localparam int unsigned PMS_IOUT_OC_WARN = 5;
  localparam int unsigned PMS_INPUT_LOW_VIN = 3;

  // Summary high byte positions.
  localparam int unsigned PMS_HI_VOUT = 7;
  localparam int unsigned PMS_HI_IOUT = 6;
  localparam int unsigned PMS_HI_INPUT = 5;
  localparam int unsigned PMS_HI_VENDOR = 4;
  localparam int unsigned PMS_HI_PNG = 3;

  // Summary low byte positions.
  localparam int unsigned PMS_LO_OFF = 6;
  localparam int unsigned PMS_LO_OV_FAULT = 5;
  localparam int unsigned PMS_LO_OC_FAULT = 4;
  localparam int unsigned PMS_LO_TEMP = 2;
  localparam int unsigned PMS_LO_COMM = 1;
  localparam int unsigned PMS_LO_OTHER = 0;

  // Defined bits of each register, all others reading as zero; PMS_VOUT_OTHER is the voltage bits that feed the other bit.
  localparam logic [7:0] PMS_VOUT_DEFINED = 8'hFC;
  localparam logic [7:0] PMS_VOUT_OTHER = 8'h7C;
  localparam logic [7:0] PMS_IOUT_DEFINED = 8'hA0;
  localparam logic [7:0] PMS_HI_DEFINED = 8'hF8;

  // Reset values.
  localparam logic [7:0] PMS_VOUT_RST = 8'h00;
  localparam logic [7:0] PMS_IOUT_RST = 8'h00;
  localparam logic PMS_LOW_VIN_RST = 1'b1;
  localparam logic [7:0] PMS_AMASK_RST = 8'h00;
  localparam logic PMS_PNG_AMASK_RST = 1'b1;

  // Index of each comparator pin in the synchronised event vector.
  localparam int unsigned PMS_EV_OV_FAULT = 0;
  localparam int unsigned PMS_EV_OV_WARN = 1;
  localparam int unsigned PMS_EV_UV_WARN = 2;
  localparam int unsigned PMS_EV_UV_FAULT = 3;
  localparam int unsigned PMS_EV_OC_FAULT = 4;
  localparam int unsigned PMS_EV_OC_WARN = 5;
  localparam int unsigned PMS_EV_VIN_ON = 6;
  localparam int unsigned PMS_EV_VIN_OFF = 7;
  localparam int unsigned PMS_EV_W = 8;

  // Latched flag update: a set in the same cycle as a clear wins.
  function automatic logic [7:0] pms_latch(input logic [7:0] cur, input logic [7:0] set,
                                           input logic [7:0] clr, input logic [7:0] defined);
    return ((cur & ~clr) | set) & defined;
  endfunction : pms_latch

  // True when any flag is set whose alert mask bit is clear.
  function automatic logic pms_any_unmasked(input logic [7:0] flags, input logic [7:0] mask);
    return |(flags & ~mask);
  endfunction : pms_any_unmasked

endpackage : pms_pkg

// *** hw/pms_sync.sv ***
`timescale 1ns/1ns
module pms_sync #(
  parameter int unsigned WIDTH = 1
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic ce_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } pms_sync_state_t;

  pms_sync_state_t st;
  pms_sync_state_t next_st;

  // Two stages; only the second stage is ever seen outside.
  always_comb begin
    next_st = st;
    if (ce_in) begin
      next_st.meta = async_in;
      next_st.stable = st.meta;
    end
  end

  // State register.
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign sync_out = st.stable;

endmodule : pms_sync

// *** hw/pms_status_bank.sv ***
`timescale 1ns/1ns
// Overview of operation
// - Summary word low byte equals summary byte.
// - High bit 7 is OR of voltage flags.
// - Summary bits ignore writes, clear via details.
// - High bit 6 is OR of current flags.
// - High bit 5 set by any input flag.
// - High bit 4 is vendor temperature/minimum OR.
// - High bit 3 is live power-not-good.
// - Power-not-good alert mask resets to one.
// - High bits 2..0 always read zero.
// - Voltage bit 7 on overvoltage fault.
// - Voltage bit 6 on overvoltage warning.
// - Voltage bit 5 on undervoltage warning.
// - Voltage bit 4 on undervoltage fault.
// - Voltage bit 3 on setpoint above maximum.
// - Voltage bit 2 on turn-on timeout.
// - Detail flags latch; each has alert mask.
// - Current bits 7 fault, 5 warning only.
// - Low-input bit live until first turn-on.
// - Later input drops latch and alert.
// - Power-off bit while converter disabled.
// - Other bit resets to one.
module pms_status_bank (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic clk_en_in,
  input wire logic link_clk_in,
  input wire logic link_req_in,
  input wire logic [pms_pkg::PMS_CMD_W-1:0] link_cmd_in,
  input wire logic link_write_in,
  input wire logic [pms_pkg::PMS_DATA_W-1:0] link_wdata_in,
  output logic link_ready_out,
  output logic link_done_out,
  output logic [pms_pkg::PMS_DATA_W-1:0] link_rdata_out,
  input wire logic ov_fault_in,
  input wire logic ov_warn_in,
  input wire logic uv_warn_in,
  input wire logic uv_fault_in,
  input wire logic oc_fault_in,
  input wire logic oc_warn_in,
  input wire logic vin_above_on_in,
  input wire logic vin_below_off_in,
  input wire logic vout_max_attempt_in,
  input wire logic turn_on_timeout_in,
  input wire logic temp_fault_warn_in,
  input wire logic vendor_otemp_in,
  input wire logic vendor_vmin_warn_in,
  input wire logic comm_summary_in,
  input wire logic converter_enabled_in,
  output logic alert_out,
  output logic alert_oe_out
);

  typedef struct packed {
    logic busy;
    logic req_tgl;
    logic [pms_pkg::PMS_CMD_W-1:0] cmd;
    logic wr;
    logic [pms_pkg::PMS_DATA_W-1:0] wdata;
    logic [pms_pkg::PMS_DATA_W-1:0] rdata;
    logic done;
    logic ack_seen;
  } pms_link_t;

  typedef struct packed {
    logic [7:0] vout;
    logic [7:0] iout;
    logic low_vin;
    logic armed;
    logic [7:0] vout_amask;
    logic [7:0] iout_amask;
    logic input_amask;
    logic png_amask;
    logic req_seen;
    logic ack_tgl;
    logic [pms_pkg::PMS_DATA_W-1:0] rdata;
    logic alert;
  } pms_core_t;

  localparam pms_core_t CORE_RST = '{
    vout: pms_pkg::PMS_VOUT_RST,
    iout: pms_pkg::PMS_IOUT_RST,
    low_vin: pms_pkg::PMS_LOW_VIN_RST,
    armed: 1'b0,
    vout_amask: pms_pkg::PMS_AMASK_RST,
    iout_amask: pms_pkg::PMS_AMASK_RST,
    input_amask: 1'b0,
    png_amask: pms_pkg::PMS_PNG_AMASK_RST,
    req_seen: 1'b0,
    ack_tgl: 1'b0,
    rdata: '0,
    alert: 1'b0
  };

  pms_link_t ls;
  pms_link_t next_ls;
  pms_core_t cs;
  pms_core_t next_cs;
  logic [pms_pkg::PMS_EV_W-1:0] ev;
  logic req_sync;
  logic ack_sync;
  logic handle;
  logic mask_wr;
  logic png;
  logic alert_now;
  logic [7:0] vout_set;
  logic [7:0] iout_set;
  logic [7:0] vout_clr;
  logic [7:0] iout_clr;
  logic [7:0] input_clr;
  logic [7:0] hi_byte;
  logic [7:0] lo_byte;
  logic [7:0] input_byte;
  logic [pms_pkg::PMS_DATA_W-1:0] read_word;

  // Comparator pins come from the analog side, so each is synchronised before use.
  pms_sync #(.WIDTH(pms_pkg::PMS_EV_W)) u_ev_sync (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .ce_in(clk_en_in),
    .async_in({vin_below_off_in, vin_above_on_in, oc_warn_in, oc_fault_in,
               uv_fault_in, uv_warn_in, ov_warn_in, ov_fault_in}),
    .sync_out(ev)
  );

  // Request toggle from the link domain into the core domain.
  pms_sync #(.WIDTH(1)) u_req_sync (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .ce_in(clk_en_in),
    .async_in(ls.req_tgl),
    .sync_out(req_sync)
  );

  // Acknowledge toggle back to the link domain; the link clock is never gated.
  pms_sync #(.WIDTH(1)) u_ack_sync (
    .clk_in(link_clk_in),
    .rst_b_in(rst_b_in),
    .ce_in(1'b1),
    .async_in(cs.ack_tgl),
    .sync_out(ack_sync)
  );

  // Link side: one transaction in flight; command fields hold still while busy,
  // which is what lets the core sample them without their own synchronisers.
  always_comb begin
    next_ls = ls;
    next_ls.done = 1'b0;
    if (!ls.busy && link_req_in) begin
      next_ls.busy = 1'b1;
      next_ls.cmd = link_cmd_in;
      next_ls.wr = link_write_in;
      next_ls.wdata = link_wdata_in;
      next_ls.req_tgl = ~ls.req_tgl;
    end
    if (ls.busy && (ack_sync != ls.ack_seen)) begin
      next_ls.busy = 1'b0;
      next_ls.ack_seen = ack_sync;
      next_ls.done = 1'b1;
      next_ls.rdata = cs.rdata;
    end
  end

  // Link state register.
  always_ff @(posedge link_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ls <= '0;
    end else begin
      ls <= next_ls;
    end
  end

  assign link_ready_out = ~ls.busy;
  assign link_done_out = ls.done;
  assign link_rdata_out = ls.rdata;
  assign handle = (req_sync != cs.req_seen);

  // Write decode: detail registers clear on ones, summary writes are dropped.
  always_comb begin
    vout_clr = 8'h00;
    iout_clr = 8'h00;
    input_clr = 8'h00;
    mask_wr = 1'b0;
    if (handle && ls.wr) begin
      case (ls.cmd)
        pms_pkg::PMS_CMD_VOUT: vout_clr = ls.wdata[7:0];
        pms_pkg::PMS_CMD_IOUT: iout_clr = ls.wdata[7:0];
        pms_pkg::PMS_CMD_INPUT: input_clr = ls.wdata[7:0];
        pms_pkg::PMS_CMD_ALERT_MASK: mask_wr = 1'b1;
        default: mask_wr = 1'b0;
      endcase
    end
  end

  // Detail flag sources.
  always_comb begin
    vout_set = 8'h00;
    vout_set[pms_pkg::PMS_VOUT_OV_FAULT] = ev[pms_pkg::PMS_EV_OV_FAULT];
    vout_set[pms_pkg::PMS_VOUT_OV_WARN] = ev[pms_pkg::PMS_EV_OV_WARN];
    vout_set[pms_pkg::PMS_VOUT_UV_WARN] = ev[pms_pkg::PMS_EV_UV_WARN];
    vout_set[pms_pkg::PMS_VOUT_UV_FAULT] = ev[pms_pkg::PMS_EV_UV_FAULT];
    vout_set[pms_pkg::PMS_VOUT_MAX_WARN] = vout_max_attempt_in;
    vout_set[pms_pkg::PMS_VOUT_TON_TIMEOUT] = turn_on_timeout_in;
    iout_set = 8'h00;
    iout_set[pms_pkg::PMS_IOUT_OC_FAULT] = ev[pms_pkg::PMS_EV_OC_FAULT];
    iout_set[pms_pkg::PMS_IOUT_OC_WARN] = ev[pms_pkg::PMS_EV_OC_WARN];
  end

  // Power-not-good is live, never latched; an input never yet turned on counts as low.
  assign png = ev[pms_pkg::PMS_EV_OV_FAULT] | ev[pms_pkg::PMS_EV_OV_WARN] |
               ev[pms_pkg::PMS_EV_UV_WARN] | ev[pms_pkg::PMS_EV_UV_FAULT] |
               turn_on_timeout_in | temp_fault_warn_in |
               ev[pms_pkg::PMS_EV_OC_FAULT] | ev[pms_pkg::PMS_EV_OC_WARN] |
               ev[pms_pkg::PMS_EV_VIN_OFF] | ~cs.armed;

  // Summary bytes are pure functions of the details and live inputs, so they cannot be written.
  always_comb begin
    hi_byte = 8'h00;
    hi_byte[pms_pkg::PMS_HI_VOUT] = |cs.vout;
    hi_byte[pms_pkg::PMS_HI_IOUT] = |cs.iout;
    hi_byte[pms_pkg::PMS_HI_INPUT] = cs.low_vin;
    hi_byte[pms_pkg::PMS_HI_VENDOR] = vendor_otemp_in | vendor_vmin_warn_in;
    hi_byte[pms_pkg::PMS_HI_PNG] = png;
    lo_byte = 8'h00;
    lo_byte[pms_pkg::PMS_LO_OFF] = ~converter_enabled_in;
    lo_byte[pms_pkg::PMS_LO_OV_FAULT] = cs.vout[pms_pkg::PMS_VOUT_OV_FAULT];
    lo_byte[pms_pkg::PMS_LO_OC_FAULT] = cs.iout[pms_pkg::PMS_IOUT_OC_FAULT];
    lo_byte[pms_pkg::PMS_LO_TEMP] = temp_fault_warn_in;
    lo_byte[pms_pkg::PMS_LO_COMM] = comm_summary_in;
    lo_byte[pms_pkg::PMS_LO_OTHER] = |(cs.vout & pms_pkg::PMS_VOUT_OTHER) |
                                     cs.iout[pms_pkg::PMS_IOUT_OC_WARN] | cs.low_vin;
    input_byte = 8'h00;
    input_byte[pms_pkg::PMS_INPUT_LOW_VIN] = cs.low_vin;
  end

  // Read mux; unmapped codes answer zero.
  always_comb begin
    case (ls.cmd)
      pms_pkg::PMS_CMD_SUMMARY: read_word = {hi_byte, lo_byte};
      pms_pkg::PMS_CMD_VOUT: read_word = {8'h00, cs.vout};
      pms_pkg::PMS_CMD_IOUT: read_word = {8'h00, cs.iout};
      pms_pkg::PMS_CMD_INPUT: read_word = {8'h00, input_byte};
      default: read_word = '0;
    endcase
  end

  // Alert: the low-input flag only counts once the input has turned on.
  assign alert_now = pms_pkg::pms_any_unmasked(cs.vout, cs.vout_amask) |
                     pms_pkg::pms_any_unmasked(cs.iout, cs.iout_amask) |
                     (cs.low_vin & cs.armed & ~cs.input_amask) |
                     (png & ~cs.png_amask);

  // Core next state.
  always_comb begin
    next_cs = cs;
    next_cs.vout = pms_pkg::pms_latch(cs.vout, vout_set, vout_clr, pms_pkg::PMS_VOUT_DEFINED);
    next_cs.iout = pms_pkg::pms_latch(cs.iout, iout_set, iout_clr, pms_pkg::PMS_IOUT_DEFINED);
    if (!cs.armed) begin
      // Before the first turn-on the bit just follows the power-up state.
      next_cs.low_vin = 1'b1;
      if (ev[pms_pkg::PMS_EV_VIN_ON]) begin
        next_cs.armed = 1'b1;
        next_cs.low_vin = 1'b0;
      end
    end else begin
      next_cs.low_vin = (cs.low_vin & ~input_clr[pms_pkg::PMS_INPUT_LOW_VIN]) |
                        ev[pms_pkg::PMS_EV_VIN_OFF];
    end
    if (mask_wr) begin
      case (ls.wdata[7:0])
        pms_pkg::PMS_CMD_VOUT: next_cs.vout_amask = ls.wdata[15:8] & pms_pkg::PMS_VOUT_DEFINED;
        pms_pkg::PMS_CMD_IOUT: next_cs.iout_amask = ls.wdata[15:8] & pms_pkg::PMS_IOUT_DEFINED;
        pms_pkg::PMS_CMD_INPUT: next_cs.input_amask = ls.wdata[pms_pkg::PMS_CMD_W + pms_pkg::PMS_INPUT_LOW_VIN];
        pms_pkg::PMS_CMD_SUMMARY: next_cs.png_amask = ls.wdata[pms_pkg::PMS_CMD_W + pms_pkg::PMS_HI_PNG];
        default: next_cs.png_amask = cs.png_amask;
      endcase
    end
    next_cs.alert = alert_now;
    if (handle) begin
      next_cs.req_seen = req_sync;
      next_cs.rdata = read_word;
      next_cs.ack_tgl = ~cs.ack_tgl;
    end
  end

  // Core state register; a low clock enable freezes everything.
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cs <= CORE_RST;
    end else if (clk_en_in) begin
      cs <= next_cs;
    end
  end

  // Open drain: the pad only ever pulls low.
  assign alert_out = 1'b0;
  assign alert_oe_out = cs.alert;

  sequence s_summary_write;
    clk_en_in && handle && ls.wr && (ls.cmd == pms_pkg::PMS_CMD_SUMMARY);
  endsequence

  sequence s_vout_clear_ov;
    clk_en_in && handle && ls.wr && (ls.cmd == pms_pkg::PMS_CMD_VOUT) &&
    ls.wdata[pms_pkg::PMS_VOUT_OV_FAULT] && !ev[pms_pkg::PMS_EV_OV_FAULT];
  endsequence

  a_word_low_byte: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    clk_en_in && handle && (ls.cmd == pms_pkg::PMS_CMD_SUMMARY) |=> cs.rdata == {$past(hi_byte), $past(lo_byte)})
    else $error("Summary word read data wrong.");

  a_volt_summary_set: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    clk_en_in && ev[pms_pkg::PMS_EV_OV_FAULT] |=>
    cs.vout[pms_pkg::PMS_VOUT_OV_FAULT] && hi_byte[pms_pkg::PMS_HI_VOUT] && lo_byte[pms_pkg::PMS_LO_OV_FAULT])
    else $error("Overvoltage fault not reflected.");

  a_summary_write_ignored: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    s_summary_write |=> ((cs.vout & $past(cs.vout)) == $past(cs.vout)) &&
    ((cs.iout & $past(cs.iout)) == $past(cs.iout)))
    else $error("Summary write cleared a flag.");

  a_cur_summary_set: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    clk_en_in && ev[pms_pkg::PMS_EV_OC_WARN] |=> cs.iout[pms_pkg::PMS_IOUT_OC_WARN] ##0 hi_byte[pms_pkg::PMS_HI_IOUT])
    else $error("Current warning not reflected.");

  a_input_drop_latch: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    clk_en_in && cs.armed && ev[pms_pkg::PMS_EV_VIN_OFF] |=> hi_byte[pms_pkg::PMS_HI_INPUT] ##1 !clk_en_in ||
    $past(input_clr[pms_pkg::PMS_INPUT_LOW_VIN]) || cs.low_vin)
    else $error("Input drop not latched.");

  a_png_live: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (turn_on_timeout_in |-> hi_byte[pms_pkg::PMS_HI_PNG]) and (vendor_otemp_in |-> hi_byte[pms_pkg::PMS_HI_VENDOR]))
    else $error("Live summary bit missing.");

  a_png_mask_hold: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    !(clk_en_in && mask_wr) && cs.png_amask |=> cs.png_amask)
    else $error("Power-not-good mask dropped by itself.");

  a_reserved_zero: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    ((hi_byte & ~pms_pkg::PMS_HI_DEFINED) == 8'h00) && ((cs.vout & ~pms_pkg::PMS_VOUT_DEFINED) == 8'h00) &&
    ((cs.iout & ~pms_pkg::PMS_IOUT_DEFINED) == 8'h00))
    else $error("Reserved bit set.");

  a_vmax_latch: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    clk_en_in && vout_max_attempt_in |=> cs.vout[pms_pkg::PMS_VOUT_MAX_WARN] ##1 !clk_en_in ||
    $past(vout_clr[pms_pkg::PMS_VOUT_MAX_WARN]) || cs.vout[pms_pkg::PMS_VOUT_MAX_WARN])
    else $error("Setpoint warning not latched.");

  a_clear_on_one: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    s_vout_clear_ov |=> !cs.vout[pms_pkg::PMS_VOUT_OV_FAULT])
    else $error("Write of one did not clear.");

  a_set_beats_clear: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    clk_en_in && vout_clr[pms_pkg::PMS_VOUT_OV_FAULT] && ev[pms_pkg::PMS_EV_OV_FAULT] |=>
    cs.vout[pms_pkg::PMS_VOUT_OV_FAULT])
    else $error("Clear beat a set.");

  a_lowvin_initial: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    !cs.armed |-> cs.low_vin && lo_byte[pms_pkg::PMS_LO_OTHER])
    else $error("Low-input bit not held before turn-on.");

  a_power_off: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    !converter_enabled_in |-> lo_byte[pms_pkg::PMS_LO_OFF])
    else $error("Power-off bit missing.");

  a_alert_follow: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    clk_en_in |=> alert_oe_out == $past(alert_now))
    else $error("Alert does not follow flags.");

  a_link_done_pulse: assert property (@(posedge link_clk_in) disable iff (!rst_b_in)
    ls.busy && (ack_sync != ls.ack_seen) |=> link_done_out && link_ready_out ##1 !link_done_out)
    else $error("Link completion pulse wrong.");

endmodule : pms_status_bank

// *** tb/pms_host_model.sv ***
`timescale 1ns/1ns
module pms_host_model (
  input wire logic link_clk_in,
  input wire logic link_ready_in,
  input wire logic link_done_in,
  input wire logic [15:0] link_rdata_in,
  output logic link_req_out,
  output logic [7:0] link_cmd_out,
  output logic link_write_out,
  output logic [15:0] link_wdata_out
);
  // The bus starts idle, with no request pending.
  initial begin
    link_req_out = 1'b0;
    link_cmd_out = 8'h00;
    link_write_out = 1'b0;
    link_wdata_out = 16'h0000;
  end

  // One transfer: a one-cycle request, qualifiers held until done, then inverted so stale data never looks live.
  // Clearing flags with ones and clearing the power-not-good mask are left to the caller.
  task automatic xfer(input logic [7:0] cmd, input logic wr, input logic [15:0] wd,
                      output logic [15:0] rd, output logic ok);
    int n;
    ok = 1'b0;
    rd = 16'h0000;
    @(negedge link_clk_in);
    for (n = 0; n < 20 && link_ready_in !== 1'b1; n++) begin
      @(negedge link_clk_in);
    end
    link_req_out = 1'b1;
    link_cmd_out = cmd;
    link_write_out = wr;
    link_wdata_out = wd;
    @(negedge link_clk_in);
    link_req_out = 1'b0;
    for (n = 0; n < 40 && !ok; n++) begin
      if (link_done_in === 1'b1) begin
        ok = 1'b1;
        rd = link_rdata_in;
      end else begin
        @(negedge link_clk_in);
      end
    end
    link_cmd_out = ~cmd;
    link_write_out = ~wr;
    link_wdata_out = ~wd;
  endtask : xfer
endmodule : pms_host_model

// *** tb/pms_status_bank_tb.sv ***
`timescale 1ns/1ns
module pms_status_bank_tb;
  logic clk_in, link_clk_in, rst_b_in, clk_en_in;
  logic [9:0] pins;
  logic [4:0] side;
  logic req, wr, ready, done, alert, alert_oe;
  logic [7:0] cmd;
  logic [15:0] wdata, rdata;
  int failures, total_checks;
  wire logic alert_line;

  // The alert line is open drain with a pull-up, so it idles high.
  assign alert_line = alert_oe ? alert : 1'b1;

  // Core clock, 4 ns period.
  initial begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end

  // Link clock, 125 ns period, offset so its phase is unrelated to the core clock.
  initial begin
    link_clk_in = 1'b0;
    #7;
    forever begin
      #62 link_clk_in = ~link_clk_in;
      #63 link_clk_in = ~link_clk_in;
    end
  end

  pms_status_bank dut (.clk_in(clk_in), .rst_b_in(rst_b_in), .clk_en_in(clk_en_in),
    .link_clk_in(link_clk_in), .link_req_in(req), .link_cmd_in(cmd), .link_write_in(wr),
    .link_wdata_in(wdata), .link_ready_out(ready), .link_done_out(done), .link_rdata_out(rdata),
    .ov_fault_in(pins[0]), .ov_warn_in(pins[1]), .uv_warn_in(pins[2]), .uv_fault_in(pins[3]),
    .vout_max_attempt_in(pins[4]), .turn_on_timeout_in(pins[5]), .oc_fault_in(pins[6]),
    .oc_warn_in(pins[7]), .vin_above_on_in(pins[8]), .vin_below_off_in(pins[9]),
    .temp_fault_warn_in(side[0]), .vendor_otemp_in(side[1]), .vendor_vmin_warn_in(side[2]),
    .comm_summary_in(side[3]), .converter_enabled_in(side[4]), .alert_out(alert),
    .alert_oe_out(alert_oe));

  pms_host_model host (.link_clk_in(link_clk_in), .link_ready_in(ready), .link_done_in(done),
    .link_rdata_in(rdata), .link_req_out(req), .link_cmd_out(cmd), .link_write_out(wr),
    .link_wdata_out(wdata));

  // Word comparison; an unknown never matches.
  task automatic check_word(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check_word

  // Single-bit comparison for handshake and alert results.
  task automatic check_bit(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check_bit

  // Read a register and compare it with the expected value.
  task automatic rd(input logic [7:0] c, input logic [15:0] exp);
    logic [15:0] v;
    logic ok;
    host.xfer(c, 1'b0, 16'h0000, v, ok);
    check_bit(ok, 1'b1);
    check_word(v, exp);
  endtask : rd

  // Write a register and check that the transfer completed.
  task automatic wr_reg(input logic [7:0] c, input logic [15:0] d);
    logic [15:0] v;
    logic ok;
    host.xfer(c, 1'b1, d, v, ok);
    check_bit(ok, 1'b1);
  endtask : wr_reg

  // Pin levels change off the sampling edge and stay long enough to pass the synchronisers.
  task automatic drive(input logic [9:0] p, input logic [4:0] s);
    @(negedge clk_in);
    pins = p;
    side = s;
    repeat (6) @(negedge clk_in);
  endtask : drive

  // Print the counts and the verdict, then end the run.
  task automatic report_and_stop;
    $display("checks=%0d failures=%0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : report_and_stop

  // Main sequence; reset also spans two link edges so both domains see it.
  initial begin
    logic [7:0] c, f, hi, lo;
    failures = 0;
    total_checks = 0;
    rst_b_in = 1'b0;
    clk_en_in = 1'b1;
    pins = 10'h000;
    side = 5'h00;
    repeat (2) @(posedge link_clk_in);
    repeat (12) @(negedge clk_in);
    rst_b_in = 1'b1;
    rd(8'h79, 16'h2841);
    rd(8'h7A, 16'h0000);
    rd(8'h7B, 16'h0000);
    check_bit(alert_line, 1'b1);
    wr_reg(8'h7C, 16'h0008);
    rd(8'h7C, 16'h0008);
    drive(10'h100, 5'h10);
    rd(8'h79, 16'h0000);
    // Each flag source in turn: live summary while held, latch after release, then clear.
    for (int i = 0; i < 8; i++) begin
      c = (i < 6) ? 8'h7A : 8'h7B;
      f = (i < 6) ? (8'h80 >> i) : ((i == 6) ? 8'h80 : 8'h20);
      hi = (i < 6) ? ((i == 4) ? 8'h80 : 8'h88) : 8'h48;
      lo = (i == 0) ? 8'h20 : ((i == 6) ? 8'h10 : 8'h01);
      drive(10'h100 | (10'h001 << i), 5'h10);
      rd(8'h79, {hi, lo});
      drive(10'h100, 5'h10);
      rd(c, {8'h00, f});
      wr_reg(8'h79, 16'hFFFF);
      rd(8'h79, {hi & 8'hF7, lo});
      check_bit(alert_line, 1'b0);
      wr_reg(c, 16'h0000);
      rd(c, {8'h00, f});
      wr_reg(c, {8'h00, f});
      rd(8'h79, 16'h0000);
      check_bit(alert_line, 1'b1);
    end
    drive(10'h1FF, 5'h10);
    drive(10'h100, 5'h10);
    rd(8'h7A, 16'h00FC);
    rd(8'h7B, 16'h00A0);
    wr_reg(8'h7A, 16'hFFFF);
    wr_reg(8'h7B, 16'hFFFF);
    rd(8'h79, 16'h0000);
    drive(10'h300, 5'h10);
    drive(10'h100, 5'h10);
    rd(8'h79, 16'h2001);
    check_bit(alert_line, 1'b0);
    wr_reg(8'h7C, 16'h0008);
    rd(8'h7C, 16'h0000);
    // Live summary sources never latch and, masked by default, never alert.
    for (int j = 0; j < 4; j++) begin
      drive(10'h100, 5'h10 | (5'h01 << j));
      rd(8'h79, (j == 0) ? 16'h0804 : ((j == 3) ? 16'h0002 : 16'h1000));
      check_bit(alert_line, 1'b1);
    end
    drive(10'h100, 5'h00);
    rd(8'h79, 16'h0040);
    wr_reg(8'h1B, 16'h807A);
    drive(10'h101, 5'h10);
    drive(10'h100, 5'h10);
    rd(8'h7A, 16'h0080);
    check_bit(alert_line, 1'b1);
    wr_reg(8'h7A, 16'h0080);
    wr_reg(8'h1B, 16'h0079);
    drive(10'h100, 5'h11);
    check_bit(alert_line, 1'b0);
    drive(10'h100, 5'h10);
    check_bit(alert_line, 1'b1);
    // A masked input drop still latches but leaves the line released.
    wr_reg(8'h1B, 16'h087C);
    drive(10'h300, 5'h10);
    drive(10'h100, 5'h10);
    rd(8'h7C, 16'h0008);
    check_bit(alert_line, 1'b1);
    wr_reg(8'h7C, 16'h0008);
    rd(8'h7C, 16'h0000);
    // With the clock enable low a comparator pulse must leave no trace.
    clk_en_in = 1'b0;
    drive(10'h101, 5'h10);
    drive(10'h100, 5'h10);
    clk_en_in = 1'b1;
    rd(8'h7A, 16'h0000);
    rd(8'h55, 16'h0000);
    report_and_stop();
  end

  // Watchdog: the sequence needs roughly a fifth of this span, so a hang is caught well before the cycle budget.
  initial begin
    #300000;
    failures++;
    report_and_stop();
  end
endmodule : pms_status_bank_tb
